// ### trace_port_pkg.sv
// constants and types for the real-time trace port
// assumes a single core clock domain; included by package reference only
package trace_port_pkg;

  localparam int NIB_W = 4;
  localparam int DATA_W = 32;
  localparam int BYTES_W = 3;
  localparam int ENTRY_W = BYTES_W + DATA_W;
  localparam int FIFO_DEPTH = 2;
  localparam int CNT_W = 4;

  //////////////////////////////////////////////////////////////////////////////
  // status codes
  localparam logic [3:0] ST_CONTINUE = 4'h0;
  localparam logic [3:0] ST_BEGIN = 4'h1;
  localparam logic [3:0] ST_RSVD_A = 4'h2;
  localparam logic [3:0] ST_USER = 4'h3;
  localparam logic [3:0] ST_TRIGGER = 4'h4;
  localparam logic [3:0] ST_BRANCH = 4'h5;
  localparam logic [3:0] ST_RSVD_B = 4'h6;
  localparam logic [3:0] ST_EXC_RETURN = 4'h7;
  localparam logic [1:0] ST_MARK_PREFIX = 2'h2;
  localparam logic [3:0] ST_MARK_2B = 4'h9;
  localparam logic [3:0] ST_EXCEPTION = 4'hc;
  localparam logic [3:0] ST_EMU_ENTRY = 4'hd;
  localparam logic [3:0] ST_STOPPED = 4'he;
  localparam logic [3:0] ST_HALTED = 4'hf;

  //////////////////////////////////////////////////////////////////////////////
  // operand sizes, target byte selection, byte counts
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] TGT_2_BYTES = 2'h0;
  localparam logic [1:0] TGT_3_BYTES = 2'h1;
  localparam logic [2:0] BYTES_1 = 3'h1;
  localparam logic [2:0] BYTES_2 = 3'h2;
  localparam logic [2:0] BYTES_3 = 3'h3;
  localparam logic [2:0] BYTES_4 = 3'h4;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [NIB_W-1:0] NIB_IDLE = 4'h0;

  typedef enum logic {DRAIN_IDLE, DRAIN_SHIFT} drain_state_t;

endpackage

// ### trace_buf_if.sv
// valid/ready carrier between trace capture, the buffer and the drain engine
// assumes producer and consumer share the buffer's clock
interface trace_buf_if #(parameter int WIDTH = trace_port_pkg::ENTRY_W);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport producer (output push_valid, output push_data, input push_ready);
  modport buffer (input push_valid, input push_data, output push_ready,
                  output pop_valid, output pop_data, input pop_ready);
  modport consumer (input pop_valid, input pop_data, output pop_ready);
endinterface

// ### trace_fifo.sv
// two-entry flip-flop fifo with valid/ready on both sides
// assumes a synchronised active-low reset from the top module
module trace_fifo #(
  parameter int WIDTH = trace_port_pkg::ENTRY_W,
  parameter int DEPTH = trace_port_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_sync_b,
  // buffer side of the carrier
  trace_buf_if.buffer buf_io
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int OCC_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W-1:0] PTR_ZERO = '0;
  localparam logic [OCC_W-1:0] OCC_FULL = OCC_W'(DEPTH);
  localparam logic [OCC_W-1:0] OCC_ONE = OCC_W'(1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [OCC_W-1:0] occ_ff;

  wire logic do_push = buf_io.push_valid && buf_io.push_ready;
  wire logic do_pop = buf_io.pop_valid && buf_io.pop_ready;
  wire logic [PTR_W-1:0] nxt_wr_ptr = (wr_ptr_ff == PTR_LAST) ? PTR_ZERO : wr_ptr_ff + PTR_W'(1);
  wire logic [PTR_W-1:0] nxt_rd_ptr = (rd_ptr_ff == PTR_LAST) ? PTR_ZERO : rd_ptr_ff + PTR_W'(1);
  wire logic [OCC_W-1:0] nxt_occ = (do_push && !do_pop) ? occ_ff + OCC_ONE :
                                   (do_pop && !do_push) ? occ_ff - OCC_ONE : occ_ff;

  // ready drops only when both entries wait, which stalls the core
  assign buf_io.push_ready = (occ_ff != OCC_FULL);
  assign buf_io.pop_valid = (occ_ff != '0);
  assign buf_io.pop_data = mem_ff[rd_ptr_ff];

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= buf_io.push_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      occ_ff <= '0;
    end else begin
      wr_ptr_ff <= do_push ? nxt_wr_ptr : wr_ptr_ff;
      rd_ptr_ff <= do_pop ? nxt_rd_ptr : rd_ptr_ff;
      occ_ff <= nxt_occ;
    end
  end

endmodule

// ### trace_port.sv
// real-time trace port: status nibble plus buffered data nibble
// assumes core event inputs are one-cycle pulses and mode inputs are levels, all on core_clk
//
// Contract
// - status and data nibbles, four bits each
// - status updates on processor clock edges
// - continue, begin, user codes; reserved never
// - taken branch and exception return codes
// - byte-count markers for one to four bytes
// - exception, emulator, stopped, halted codes
// - multicycle codes held while mode lasts
// - other codes re-evaluated every cycle
// - marker one cycle before first nibble
// - variant branch target follows branch code
// - target bytes selectable two, three, four
// - two-entry 32-bit fifo feeds data nibble
// - stall core only while fifo full
// - data output never otherwise slows core
// - instruction code on first execute cycle
// - one nibble per clock, low first
// - trigger instruction emits code 0100
// - write-data instruction outputs operand, code 0100
module trace_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // single-cycle core events, valid in the first execute cycle
  input wire logic instr_begin,
  input wire logic user_mode_entry,
  input wire logic taken_branch,
  input wire logic exception_return_instruction,
  input wire logic trigger_marker_instruction,
  input wire logic write_trace_data_instruction,
  input wire logic [1:0] write_trace_data_size,
  input wire logic [31:0] write_trace_data_operand,
  // multicycle core modes
  input wire logic exception_active,
  input wire logic emulator_entry_active,
  input wire logic stopped_wait,
  input wire logic halted,
  // data capture from the core bus
  input wire logic variant_target_valid,
  input wire logic [31:0] variant_target,
  input wire logic operand_capture_valid,
  input wire logic [1:0] operand_capture_size,
  input wire logic [31:0] operand_capture_data,
  // configuration
  input wire logic [1:0] target_bytes_sel,
  // trace pins
  output logic [3:0] core_status_code,
  output logic [3:0] trace_data_nibble,
  // core back-pressure
  output logic core_stall
);

  //////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // capture side
  trace_buf_if #(.WIDTH(trace_port_pkg::ENTRY_W)) buf_if ();

  trace_fifo #(
    .WIDTH(trace_port_pkg::ENTRY_W),
    .DEPTH(trace_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_sync_b(rst_sync_ff),
    .buf_io(buf_if.buffer)
  );

  wire logic [2:0] wdd_bytes = (write_trace_data_size == trace_port_pkg::SIZE_BYTE) ? trace_port_pkg::BYTES_1 :
                               (write_trace_data_size == trace_port_pkg::SIZE_WORD) ? trace_port_pkg::BYTES_2 :
                               trace_port_pkg::BYTES_4;
  wire logic [2:0] opnd_bytes = (operand_capture_size == trace_port_pkg::SIZE_BYTE) ? trace_port_pkg::BYTES_1 :
                                (operand_capture_size == trace_port_pkg::SIZE_WORD) ? trace_port_pkg::BYTES_2 :
                                trace_port_pkg::BYTES_4;
  wire logic [2:0] tgt_bytes = (target_bytes_sel == trace_port_pkg::TGT_2_BYTES) ? trace_port_pkg::BYTES_2 :
                               (target_bytes_sel == trace_port_pkg::TGT_3_BYTES) ? trace_port_pkg::BYTES_3 :
                               trace_port_pkg::BYTES_4;

  // one capture per cycle; write-data wins since it ignores configuration
  assign buf_if.push_valid = write_trace_data_instruction || variant_target_valid || operand_capture_valid;
  assign buf_if.push_data = write_trace_data_instruction ? {wdd_bytes, write_trace_data_operand} :
                            variant_target_valid ? {tgt_bytes, variant_target} :
                            {opnd_bytes, operand_capture_data};

  // stall only while both entries are occupied
  assign core_stall = !buf_if.push_ready;

  //////////////////////////////////////////////////////////////////////////////
  // status selection
  wire logic mc_active = halted || emulator_entry_active || exception_active || stopped_wait;
  wire logic [3:0] mc_code = halted ? trace_port_pkg::ST_HALTED :
                             emulator_entry_active ? trace_port_pkg::ST_EMU_ENTRY :
                             exception_active ? trace_port_pkg::ST_EXCEPTION :
                             trace_port_pkg::ST_STOPPED;
  // a write-data held through a stall has not executed yet and must not block the drain
  wire logic trig_any = trigger_marker_instruction || (write_trace_data_instruction && buf_if.push_ready);
  wire logic ev_any = exception_return_instruction || taken_branch || trig_any || user_mode_entry || instr_begin;
  wire logic [3:0] ev_code = exception_return_instruction ? trace_port_pkg::ST_EXC_RETURN :
                             taken_branch ? trace_port_pkg::ST_BRANCH :
                             trig_any ? trace_port_pkg::ST_TRIGGER :
                             user_mode_entry ? trace_port_pkg::ST_USER :
                             instr_begin ? trace_port_pkg::ST_BEGIN :
                             trace_port_pkg::ST_CONTINUE;

  //////////////////////////////////////////////////////////////////////////////
  // drain engine
  trace_port_pkg::drain_state_t state_ff;
  logic [trace_port_pkg::CNT_W-1:0] cnt_ff;
  logic [trace_port_pkg::DATA_W-1:0] shift_ff;
  logic [3:0] status_ff;
  logic [3:0] data_ff;

  // a marker only takes a free status slot, so no core event is ever hidden
  wire logic slot_free = !mc_active && !ev_any;
  wire logic shifting = (state_ff == trace_port_pkg::DRAIN_SHIFT);
  wire logic last_nib = shifting && (cnt_ff == trace_port_pkg::CNT_ONE);
  wire logic start = (state_ff == trace_port_pkg::DRAIN_IDLE) && buf_if.pop_valid && slot_free;
  wire logic [2:0] pop_bytes = buf_if.pop_data[trace_port_pkg::ENTRY_W-1:trace_port_pkg::DATA_W];
  wire logic [2:0] pop_bytes_m1 = pop_bytes - trace_port_pkg::BYTES_1;
  wire logic [3:0] marker_code = {trace_port_pkg::ST_MARK_PREFIX, pop_bytes_m1[1:0]};
  wire logic [trace_port_pkg::CNT_W-1:0] pop_nibbles = {pop_bytes, 1'b0};

  assign buf_if.pop_ready = start;

  wire logic [3:0] nxt_status = mc_active ? mc_code :
                                ev_any ? ev_code :
                                start ? marker_code :
                                trace_port_pkg::ST_CONTINUE;
  wire trace_port_pkg::drain_state_t nxt_state = start ? trace_port_pkg::DRAIN_SHIFT :
                                                 last_nib ? trace_port_pkg::DRAIN_IDLE : state_ff;
  wire logic [trace_port_pkg::CNT_W-1:0] nxt_cnt = start ? pop_nibbles :
                                                   shifting ? cnt_ff - trace_port_pkg::CNT_ONE : cnt_ff;
  wire logic [trace_port_pkg::DATA_W-1:0] nxt_shift = start ? buf_if.pop_data[trace_port_pkg::DATA_W-1:0] :
                                                      shifting ? (shift_ff >> trace_port_pkg::NIB_W) : shift_ff;
  wire logic [3:0] nxt_data = shifting ? shift_ff[trace_port_pkg::NIB_W-1:0] : trace_port_pkg::NIB_IDLE;

  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= trace_port_pkg::DRAIN_IDLE;
      cnt_ff <= '0;
      shift_ff <= '0;
      status_ff <= trace_port_pkg::ST_CONTINUE;
      data_ff <= trace_port_pkg::NIB_IDLE;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      status_ff <= nxt_status;
      data_ff <= nxt_data;
    end
  end

  // both nibbles come straight from flip-flops
  assign core_status_code = status_ff;
  assign trace_data_nibble = data_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_ff);

  wire logic is_marker = (status_ff[3:2] == trace_port_pkg::ST_MARK_PREFIX);

  sequence s_marker_2b;
    status_ff == trace_port_pkg::ST_MARK_2B;
  endsequence

  sequence s_four_nibbles;
    shifting [*4] ##1 !shifting;
  endsequence

  chk_reserved_codes: assert property (
    status_ff != trace_port_pkg::ST_RSVD_A && status_ff != trace_port_pkg::ST_RSVD_B)
    else $error("reserved status code driven");

  chk_halt_hold: assert property (
    halted |=> core_status_code == trace_port_pkg::ST_HALTED)
    else $error("halted mode not shown on status");

  chk_stop_hold: assert property (
    (stopped_wait && !halted && !emulator_entry_active && !exception_active) [*2]
      |=> core_status_code == trace_port_pkg::ST_STOPPED)
    else $error("stopped mode not held on status");

  chk_branch_code: assert property (
    (taken_branch && !exception_return_instruction && !mc_active) |=> core_status_code == trace_port_pkg::ST_BRANCH)
    else $error("taken branch code missing");

  chk_trigger_code: assert property (
    (trig_any && !taken_branch && !exception_return_instruction && !mc_active)
      |=> core_status_code == trace_port_pkg::ST_TRIGGER)
    else $error("trigger code missing");

  chk_begin_code: assert property (
    (instr_begin && !mc_active && !trig_any && !taken_branch && !exception_return_instruction && !user_mode_entry)
      |=> core_status_code == trace_port_pkg::ST_BEGIN)
    else $error("instruction begin code missing");

  chk_marker_lead: assert property (
    is_marker |=> (trace_data_nibble == $past(shift_ff[3:0]) && shifting))
    else $error("first nibble not one cycle after marker");

  chk_word_length: assert property (
    s_marker_2b |-> s_four_nibbles)
    else $error("two-byte transfer not four nibbles");

  chk_stall_full: assert property (
    core_stall == (u_fifo.occ_ff == 2'(trace_port_pkg::FIFO_DEPTH)))
    else $error("stall not tied to full fifo");

  chk_target_bytes: assert property (
    (variant_target_valid && !write_trace_data_instruction && target_bytes_sel == trace_port_pkg::TGT_3_BYTES)
      |-> buf_if.push_data[trace_port_pkg::ENTRY_W-1:trace_port_pkg::DATA_W] == trace_port_pkg::BYTES_3)
    else $error("target byte count not from selection");

  chk_stall_release: assert property (
    (core_stall && buf_if.pop_ready) |=> !core_stall)
    else $error("stall held after an entry was freed");

  chk_exc_return: assert property (
    (exception_return_instruction && !mc_active) |=> core_status_code == trace_port_pkg::ST_EXC_RETURN)
    else $error("exception return code missing");

  chk_user_code: assert property (
    (user_mode_entry && !mc_active && !exception_return_instruction && !taken_branch && !trig_any)
      |=> core_status_code == trace_port_pkg::ST_USER)
    else $error("user mode entry code missing");

  chk_emu_hold: assert property (
    (emulator_entry_active && !halted) |=> core_status_code == trace_port_pkg::ST_EMU_ENTRY)
    else $error("emulator entry mode not shown on status");

  chk_exc_hold: assert property (
    (exception_active && !halted && !emulator_entry_active)
      |=> core_status_code == trace_port_pkg::ST_EXCEPTION)
    else $error("exception mode not held on status");

  chk_continue_idle: assert property (
    (!mc_active && !ev_any && !start) |=> core_status_code == trace_port_pkg::ST_CONTINUE)
    else $error("idle cycle not shown as continue");

  chk_marker_bytes: assert property (
    (start && pop_bytes == trace_port_pkg::BYTES_2) |=> s_marker_2b)
    else $error("two-byte marker code missing");

  chk_data_idle: assert property (
    !shifting |=> trace_data_nibble == trace_port_pkg::NIB_IDLE)
    else $error("data nibble not idle outside a transfer");

  wire logic [trace_port_pkg::NIB_W-1:0] pop_low_nib = buf_if.pop_data[trace_port_pkg::NIB_W-1:0];
  chk_first_nibble: assert property (
    start |=> ##1 trace_data_nibble == $past(pop_low_nib, 2))
    else $error("first nibble not the least significant one");

  chk_long_length: assert property (
    (start && pop_bytes == trace_port_pkg::BYTES_4) |=> shifting [*8] ##1 !shifting)
    else $error("four-byte transfer not eight nibbles");

  chk_write_code: assert property (
    (write_trace_data_instruction && !core_stall && !taken_branch && !exception_return_instruction && !mc_active)
      |=> core_status_code == trace_port_pkg::ST_TRIGGER)
    else $error("write-data code missing");

  chk_write_push: assert property (
    (write_trace_data_instruction && !core_stall)
      |-> (buf_if.push_valid && buf_if.push_data[trace_port_pkg::DATA_W-1:0] == write_trace_data_operand))
    else $error("write-data operand not captured");

  chk_halt_drain: assert property (
    halted |-> !buf_if.pop_ready)
    else $error("drain started while halted");

  chk_stop_code: assert property (
    (stopped_wait && !halted && !emulator_entry_active && !exception_active)
      |=> core_status_code == trace_port_pkg::ST_STOPPED)
    else $error("stopped mode not shown on status");

  chk_target_two: assert property (
    (variant_target_valid && !write_trace_data_instruction && target_bytes_sel == trace_port_pkg::TGT_2_BYTES)
      |-> buf_if.push_data[trace_port_pkg::ENTRY_W-1:trace_port_pkg::DATA_W] == trace_port_pkg::BYTES_2)
    else $error("two-byte target count not from selection");

  chk_data_end: assert property (
    last_nib |=> ##1 trace_data_nibble == trace_port_pkg::NIB_IDLE)
    else $error("data nibble not idle after last nibble");

endmodule

// ### trace_sink_model.sv
// development-system model: rebuilds buffered transfers from the trace pins
// assumes both nibbles are sampled on rising core_clk edges
module trace_sink_model (
  // clock
  input wire logic core_clk,
  // trace pins
  input wire logic [3:0] core_status_code,
  input wire logic [3:0] trace_data_nibble
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] n_bytes;
  logic [31:0] acc;
  int left = 0;
  int pos = 0;
  int bad_codes = 0;
  logic [34:0] got[$];
  //////////////////////////////////////////////////////////////////////////////
  // a marker seen mid-transfer is ignored, so a displaced entry shows as bad data
  always @(posedge core_clk) begin
    if (left > 0) begin
      acc[pos*4 +: 4] = trace_data_nibble;
      pos++;
      left--;
      if (left == 0) got.push_back({n_bytes, acc});
    end else if (core_status_code[3:2] == 2'h2) begin
      n_bytes = 3'(core_status_code[1:0]) + 3'h1;
      acc = 32'h0;
      pos = 0;
      left = int'(n_bytes) * 2;
    end
    if (core_status_code == 4'h2 || core_status_code == 4'h6) bad_codes++;
  end
endmodule

// ### realtime_trace_port_test.sv
// self-checking bench for the trace port
// assumes the sink model watches the pins; inputs change 1 ns after rising edges
module realtime_trace_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] ev = 5'h0;
  logic [3:0] lv = 4'h0;
  logic [2:0] cv = 3'h0;
  logic [1:0] sz = 2'h0;
  logic [1:0] sel = 2'h0;
  logic [31:0] dat = 32'h0;
  logic [3:0] core_status_code;
  logic [3:0] trace_data_nibble;
  logic core_stall;
  int n_errors = 0;
  int n_compared = 0;
  integer seed = 32'he085;
  logic [34:0] exp_q[$];
  logic [3:0] ev_code[5] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'h4};
  logic [3:0] lv_code[4] = '{4'hc, 4'hd, 4'he, 4'hf};

  trace_port uut (
    .core_clk(core_clk), .rst_b(rst_b),
    .instr_begin(ev[0]), .user_mode_entry(ev[1]), .taken_branch(ev[2]),
    .exception_return_instruction(ev[3]), .trigger_marker_instruction(ev[4]),
    .write_trace_data_instruction(cv[0]), .write_trace_data_size(sz), .write_trace_data_operand(dat),
    .exception_active(lv[0]), .emulator_entry_active(lv[1]), .stopped_wait(lv[2]), .halted(lv[3]),
    .variant_target_valid(cv[1]), .variant_target(dat),
    .operand_capture_valid(cv[2]), .operand_capture_size(sz), .operand_capture_data(dat),
    .target_bytes_sel(sel),
    .core_status_code(core_status_code), .trace_data_nibble(trace_data_nibble), .core_stall(core_stall));

  trace_sink_model partner (
    .core_clk(core_clk), .core_status_code(core_status_code), .trace_data_nibble(trace_data_nibble));

  initial begin
    forever #2 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] size_bytes(input logic [1:0] s);
    return (s == 2'h0) ? 3'h1 : (s == 2'h1) ? 3'h2 : 3'h4;
  endfunction

  function automatic logic [2:0] sel_bytes(input logic [1:0] s);
    return (s == 2'h0) ? 3'h2 : (s == 2'h1) ? 3'h3 : 3'h4;
  endfunction

  function automatic logic [34:0] expect_entry(input logic [2:0] b, input logic [31:0] v);
    logic [31:0] m;
    m = (b == 3'h4) ? 32'hffffffff : ((32'h1 << (8 * b)) - 32'h1);
    return {b, v & m};
  endfunction

  task automatic check(input logic [34:0] got, input logic [34:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  // one capture of kind k; held while the buffer is full
  task automatic push(input int k);
    int w;
    cv = 3'h1 << k;
    for (w = 0; w < 100 && core_stall !== 1'b0; w++) tick();
    if (w == 100) begin
      n_errors++;
      test_done();
    end
    tick();
    // strobe stays up; the next request, the drain or the caller changes it
    exp_q.push_back(expect_entry((k == 1) ? sel_bytes(sel) : size_bytes(sz), dat));
    if (k == 0 && lv == 4'h0) check(core_status_code, 4'h4);
  endtask

  task automatic drain;
    int w;
    cv = 3'h0;
    for (w = 0; w < 400 && partner.got.size() < exp_q.size(); w++) tick();
    if (w == 400) begin
      n_errors++;
      test_done();
    end
    check(partner.got.size(), exp_q.size());
    while (partner.got.size() > 0 && exp_q.size() > 0) begin
      check(partner.got.pop_front(), exp_q.pop_front());
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    int j;
    repeat (16) @(posedge core_clk);
    #1 rst_b = 1'b1;
    repeat (3) tick();
    // single-cycle codes, then back to continue
    for (i = 0; i < 5; i++) begin
      ev = 5'h1 << i;
      tick();
      ev = 5'h0;
      check(core_status_code, ev_code[i]);
      tick();
      check(core_status_code, 4'h0);
    end
    // multicycle codes win over events and stand while the mode lasts
    for (i = 0; i < 4; i++) begin
      lv = 4'h1 << i;
      ev = 5'h1f;
      for (j = 0; j < 5; j++) begin
        tick();
        ev = 5'h0;
        check(core_status_code, lv_code[i]);
      end
      lv = 4'h0;
      tick();
      check(core_status_code, 4'h0);
    end
    lv = 4'hf;
    tick();
    check(core_status_code, 4'hf);
    lv = 4'h0;
    tick();
    // random captures of every kind, size and target width
    for (i = 0; i < 24; i++) begin
      sz = 2'($random(seed));
      sel = 2'($random(seed));
      dat = $random(seed);
      push(i % 3);
      if (i % 4 == 3) drain();
    end
    drain();
    // fill while halted: drain stops, second entry raises stall
    lv = 4'h8;
    tick();
    dat = 32'hcafe1234;
    sel = 2'h3;
    push(1);
    check(core_stall, 1'b0);
    dat = 32'h89abcdef;
    sz = 2'h2;
    push(2);
    check(core_stall, 1'b1);
    cv = 3'h0;
    repeat (3) tick();
    check(core_stall, 1'b1);
    lv = 4'h0;
    dat = 32'h0000005a;
    sz = 2'h0;
    push(0);
    drain();
    check(partner.bad_codes, 0);
    test_done();
  end
endmodule
